// file: pkg/mode_map_pkg.sv
// shared constants and types for mode selection and resource mapping
package mode_map_pkg;
    // operating modes, coded as debug pin, mode b, mode a
    typedef enum logic [2:0] {
        SPECIAL_SINGLE = 3'h0,
        SPECIAL_NARROW = 3'h1,
        SPECIAL_PERIPH = 3'h2,
        SPECIAL_WIDE   = 3'h3,
        NORMAL_SINGLE  = 3'h4,
        NORMAL_NARROW  = 3'h5,
        RESERVED_MODE  = 3'h6,
        NORMAL_WIDE    = 3'h7
    } mode_e;

    // background debug states, gray along off, enabled, active
    typedef enum logic [1:0] {
        DBG_OFF     = 2'h0,
        DBG_ENABLED = 2'h1,
        DBG_ACTIVE  = 2'h3
    } debug_e;

    // external transfer sequencer states
    typedef enum logic [1:0] {
        EXT_IDLE   = 2'h0,
        EXT_SECOND = 2'h1
    } ext_e;

    // position register selects on the write port
    localparam logic [1:0] POS_REGS = 2'h0;
    localparam logic [1:0] POS_RAM  = 2'h1;
    localparam logic [1:0] POS_EE   = 2'h2;

    // field positions inside the position bytes
    localparam int BASE5_LSB = 3;
    localparam int EE_BASE_LSB = 4;
    localparam int EE_ON_BIT = 0;

    // position values after reset
    localparam logic [7:0] REG_POS_RESET   = 8'h00;
    localparam logic [7:0] RAM_POS_RESET   = 8'h08;
    localparam logic [7:0] EE_POS_EXPANDED = 8'h11;
    localparam logic [7:0] EE_POS_SINGLE   = 8'hF1;

    // one-hot resource select bit positions
    localparam int SEL_W       = 6;
    localparam int SEL_DBG_ROM = 0;
    localparam int SEL_DBG_REG = 1;
    localparam int SEL_REGS    = 2;
    localparam int SEL_RAM     = 3;
    localparam int SEL_EE      = 4;
    localparam int SEL_EXT     = 5;

    // debug overlay addresses
    localparam logic [15:0] DBG_REG_FIRST = 16'hFF00;
    localparam logic [15:0] DBG_REG_LAST  = 16'hFF06;
    localparam logic [15:0] DBG_ROM_FIRST = 16'hFF20;

    // expansion windows
    localparam logic [15:0] PROG_WIN_FIRST  = 16'h8000;
    localparam logic [15:0] PROG_WIN_LAST   = 16'hBFFF;
    localparam logic [15:0] DATA_WIN_FIRST  = 16'h7000;
    localparam logic [15:0] DATA_WIN_LAST   = 16'h7FFF;
    localparam logic [5:0]  EXTRA_DIRECT    = 6'h00;
    localparam logic [5:0]  EXTRA_UPPER     = 6'h01;

    // cycles from position write to new decoding
    localparam int MAP_SETTLE_CYCLES = 2;

    // modes with no external bus
    function automatic logic is_single(input mode_e m);
        return (m == SPECIAL_SINGLE) || (m == NORMAL_SINGLE);
    endfunction

    // modes with an 8-bit external data bus
    function automatic logic is_narrow(input mode_e m);
        return (m == SPECIAL_NARROW) || (m == NORMAL_NARROW);
    endfunction

    // modes with the debug pin low at reset
    function automatic logic is_special(input mode_e m);
        return (m[2] == 1'b0);
    endfunction
endpackage

// file: logic/resource_decoder.sv
// combinational decode of one address onto one internal resource or the external bus
`timescale 1ns/1ps
module resource_decoder (
    input  wire logic [15:0] addr,         // bus address
    input  wire logic        debug_active, // debug overlay present
    input  wire logic [4:0]  regs_base,    // register block 2k slot
    input  wire logic [4:0]  ram_base,     // ram 2k slot
    input  wire logic [3:0]  ee_base,      // eeprom 4k slot
    input  wire logic        ee_on,        // eeprom present in map
    output logic [mode_map_pkg::SEL_W-1:0] sel // one-hot select
);
    logic hit_regs; // register block match
    logic hit_ram;  // ram match
    logic hit_ee;   // eeprom match
    logic hit_top;  // top page held by debug

    // resource windows
    always_comb begin
        hit_regs = (addr[15:11] == regs_base) && (addr[10:9] == 2'h0);
        hit_ram  = (addr[15:11] == ram_base) && addr[10];
        hit_ee   = ee_on && (addr[15:12] == ee_base);
        hit_top  = debug_active
                   && (addr >= mode_map_pkg::DBG_REG_FIRST);
    end

    // fixed precedence, leftovers go external
    always_comb begin
        sel = '0;
        if (hit_top) begin
            if (addr <= mode_map_pkg::DBG_REG_LAST) begin
                sel[mode_map_pkg::SEL_DBG_REG] = 1'b1;
            end else begin
                sel[mode_map_pkg::SEL_DBG_ROM] = 1'b1;
            end
        end else if (hit_regs) begin
            sel[mode_map_pkg::SEL_REGS] = 1'b1;
        end else if (hit_ram) begin
            sel[mode_map_pkg::SEL_RAM] = 1'b1;
        end else if (hit_ee) begin
            sel[mode_map_pkg::SEL_EE] = 1'b1;
        end else begin
            sel[mode_map_pkg::SEL_EXT] = 1'b1;
        end
    end
endmodule

// file: logic/mode_select_resource_map.sv
// mode capture, bus port roles, debug overlay and resource mapping
`timescale 1ns/1ps
module mode_select_resource_map (
    input  wire logic        clk,                  // bus clock
    input  wire logic        reset,                // sync reset, high
    input  wire logic        debug_pin,            // mode pin, async
    input  wire logic        mode_select_b,        // mode pin, async
    input  wire logic        mode_select_a,        // mode pin, async
    input  wire logic        port_d_emulate,       // emulation bit
    input  wire logic        internal_visibility,  // visibility bit
    input  wire logic        debug_enable_cmd,     // enable pulse
    input  wire logic        debug_serial_cmd,     // serial entry pulse
    input  wire logic        background_entry_instruction, // pulse
    input  wire logic        debug_exit,           // leave active pulse
    input  wire logic        pos_wr,               // position write
    input  wire logic [1:0]  pos_sel,              // which position
    input  wire logic [7:0]  pos_data,             // position value
    input  wire logic        bus_cycle,            // cpu access valid
    input  wire logic [15:0] bus_addr,             // cpu address
    input  wire logic        extra_window_en,      // extra page on
    input  wire logic        extra_window_direct,  // low slot select
    input  wire logic        ext_start,            // external transfer
    input  wire logic        ext_word,             // 16-bit transfer
    input  wire logic [15:0] ext_addr,             // transfer address
    input  wire logic [15:0] ext_wdata,            // transfer data
    output logic [2:0]       mode_bits,            // active mode
    output logic             ports_ab_address,     // a,b address bus
    output logic             port_c_data,          // c data bus
    output logic             port_d_data,          // d data bus
    output logic             port_e_bus_ctl,       // e bus control
    output logic             port_d_visible,       // d shows internals
    output logic             cpu_inactive,         // cpu halted
    output logic             debug_enabled,        // debug enabled
    output logic             debug_active,         // debug active
    output logic [7:0]       register_block_position, // position
    output logic [7:0]       ram_position,         // position
    output logic [7:0]       eeprom_position,      // position
    output logic             access_valid,         // select valid
    output logic [mode_map_pkg::SEL_W-1:0] access_sel, // one-hot
    output logic             program_window_hit,   // window hit
    output logic             data_window_hit,      // window hit
    output logic             extra_page_window,    // window hit
    output logic             ext_cycle,            // external cycle
    output logic [15:0]      ext_cycle_addr,       // cycle address
    output logic [7:0]       ext_port_c,           // port c byte
    output logic [7:0]       ext_port_d,           // port d byte
    output logic             ext_busy              // second cycle due
);
    localparam int PINS = 3; // mode pins

    logic [PINS-1:0] pin_raw;  // pins packed
    logic [PINS-1:0] s1;       // first stage
    logic [PINS-1:0] s2;       // second stage
    logic [PINS-1:0] s3;       // third stage
    logic [PINS-1:0] pin_flt;  // agreed level
    logic [PINS-1:0] next_pin_flt;
    mode_map_pkg::mode_e mode, next_mode, pin_mode; // mode
    mode_map_pkg::debug_e dbg, next_dbg;            // debug state
    logic [7:0] stage [3];      // written, not yet active
    logic [7:0] next_stage [3];
    logic [7:0] act [3];        // active positions
    logic [2:0] locked, next_locked; // written once
    logic [mode_map_pkg::SEL_W-1:0] dec_sel; // decoder result
    logic [15:0] addr_q;        // address of registered select
    logic        dbg_q;         // debug state at that access
    mode_map_pkg::ext_e ext_st, next_ext_st; // transfer state
    logic [7:0]  low_byte, next_low_byte;    // held low byte

    assign pin_raw = {debug_pin, mode_select_b, mode_select_a};

    // three-stage synchronisers per pin
    for (genvar i = 0; i < PINS; i++) begin : g_sync
        always_ff @(posedge clk) begin
            s1[i] <= pin_raw[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
        end
    end

    // pin level accepted once two stages agree
    always_comb begin
        next_pin_flt = pin_flt;
        for (int i = 0; i < PINS; i++) begin
            if (s2[i] == s3[i]) begin
                next_pin_flt[i] = s3[i];
            end
        end
        pin_mode = mode_map_pkg::mode_e'(next_pin_flt);
        if (pin_mode == mode_map_pkg::RESERVED_MODE) begin
            pin_mode = mode_map_pkg::SPECIAL_PERIPH;
        end
    end

    // mode tracks pins in reset, frozen afterwards
    always_comb begin
        next_mode = reset ? pin_mode : mode;
    end

    always_ff @(posedge clk) begin
        pin_flt <= next_pin_flt;
        mode    <= next_mode;
    end

    // debug enable and activation
    always_comb begin
        next_dbg = dbg;
        if (reset) begin
            next_dbg = (pin_mode == mode_map_pkg::SPECIAL_SINGLE) ?
                       mode_map_pkg::DBG_ACTIVE :
                       mode_map_pkg::DBG_OFF;
        end else begin
            unique case (dbg)
                mode_map_pkg::DBG_OFF: begin
                    if (debug_enable_cmd) begin
                        next_dbg = mode_map_pkg::DBG_ENABLED;
                    end
                end
                mode_map_pkg::DBG_ENABLED: begin
                    if (debug_serial_cmd
                        || background_entry_instruction) begin
                        next_dbg = mode_map_pkg::DBG_ACTIVE;
                    end
                end
                mode_map_pkg::DBG_ACTIVE: begin
                    if (debug_exit) begin
                        next_dbg = mode_map_pkg::DBG_ENABLED;
                    end
                end
                default: next_dbg = mode_map_pkg::DBG_OFF;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        dbg <= next_dbg;
    end

    // position writes, write-once in normal modes
    always_comb begin
        next_stage  = stage;
        next_locked = locked;
        if (reset) begin
            next_stage[0] = mode_map_pkg::REG_POS_RESET;
            next_stage[1] = mode_map_pkg::RAM_POS_RESET;
            next_stage[2] = mode_map_pkg::is_single(pin_mode) ?
                            mode_map_pkg::EE_POS_SINGLE :
                            mode_map_pkg::EE_POS_EXPANDED;
            next_locked   = 3'h0;
        end else if (pos_wr && (pos_sel <= mode_map_pkg::POS_EE)) begin
            if (!locked[pos_sel]
                || mode_map_pkg::is_special(mode)) begin
                next_stage[pos_sel] = pos_data;
            end else if (pos_sel == mode_map_pkg::POS_EE) begin
                // eeprom on bit stays writable, except in single-chip modes where it is held at 1
                next_stage[2][mode_map_pkg::EE_ON_BIT] =
                    pos_data[mode_map_pkg::EE_ON_BIT];
            end
            if (!mode_map_pkg::is_special(mode)) begin
                next_locked[pos_sel] = 1'b1;
            end
        end
        if (mode_map_pkg::is_single(mode)) begin
            next_stage[2][mode_map_pkg::EE_ON_BIT] = 1'b1;
        end
    end

    // staged value becomes active one cycle later
    always_ff @(posedge clk) begin
        stage  <= next_stage;
        locked <= next_locked;
        act    <= stage;
    end

    resource_decoder u_dec (
        .addr         (bus_addr),
        .debug_active (dbg == mode_map_pkg::DBG_ACTIVE),
        .regs_base    (act[0][mode_map_pkg::BASE5_LSB +: 5]),
        .ram_base     (act[1][mode_map_pkg::BASE5_LSB +: 5]),
        .ee_base      (act[2][mode_map_pkg::EE_BASE_LSB +: 4]),
        .ee_on        (act[2][mode_map_pkg::EE_ON_BIT]),
        .sel          (dec_sel)
    );

    // external transfer sequencing, narrow splits words
    always_comb begin
        next_ext_st   = mode_map_pkg::EXT_IDLE;
        next_low_byte = low_byte;
        if (!reset && ext_st == mode_map_pkg::EXT_IDLE && ext_start
            && !mode_map_pkg::is_single(mode)
            && mode != mode_map_pkg::SPECIAL_PERIPH) begin
            next_low_byte = ext_wdata[7:0];
            if (mode_map_pkg::is_narrow(mode) && ext_word) begin
                next_ext_st = mode_map_pkg::EXT_SECOND;
            end
        end
    end

    always_ff @(posedge clk) begin
        ext_st   <= next_ext_st;
        low_byte <= next_low_byte;
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_bits        <= 3'h0;
            ports_ab_address <= 1'b0;
            port_c_data      <= 1'b0;
            port_d_data      <= 1'b0;
            port_e_bus_ctl   <= 1'b0;
            port_d_visible   <= 1'b0;
            cpu_inactive     <= 1'b0;
            access_valid     <= 1'b0;
            access_sel       <= '0;
            addr_q           <= 16'h0000;
            dbg_q            <= 1'b0;
            program_window_hit <= 1'b0;
            data_window_hit  <= 1'b0;
            extra_page_window <= 1'b0;
            ext_cycle        <= 1'b0;
            ext_cycle_addr   <= 16'h0000;
            ext_port_c       <= 8'h00;
            ext_port_d       <= 8'h00;
        end else begin
            mode_bits        <= mode;
            ports_ab_address <= !mode_map_pkg::is_single(mode);
            port_c_data      <= !mode_map_pkg::is_single(mode);
            port_d_data      <= mode[1];
            port_e_bus_ctl   <= (mode == mode_map_pkg::SPECIAL_WIDE);
            port_d_visible   <= (mode == mode_map_pkg::SPECIAL_NARROW)
                                && port_d_emulate
                                && internal_visibility;
            cpu_inactive     <= (mode == mode_map_pkg::SPECIAL_PERIPH);
            access_valid     <= bus_cycle;
            access_sel       <= bus_cycle ? dec_sel : '0;
            addr_q           <= bus_addr;
            dbg_q            <= (dbg == mode_map_pkg::DBG_ACTIVE);
            program_window_hit <= bus_cycle
                && !mode_map_pkg::is_single(mode)
                && bus_addr >= mode_map_pkg::PROG_WIN_FIRST
                && bus_addr <= mode_map_pkg::PROG_WIN_LAST;
            data_window_hit  <= bus_cycle
                && !mode_map_pkg::is_single(mode)
                && bus_addr >= mode_map_pkg::DATA_WIN_FIRST
                && bus_addr <= mode_map_pkg::DATA_WIN_LAST;
            extra_page_window <= bus_cycle && extra_window_en
                && !mode_map_pkg::is_single(mode)
                && bus_addr[15:10] == (extra_window_direct ?
                   mode_map_pkg::EXTRA_DIRECT :
                   mode_map_pkg::EXTRA_UPPER);
            if (ext_st == mode_map_pkg::EXT_SECOND) begin
                ext_cycle      <= 1'b1;
                ext_cycle_addr <= ext_cycle_addr + 16'h0001;
                ext_port_c     <= low_byte;
                ext_port_d     <= 8'h00;
            end else if (ext_start && ext_st == mode_map_pkg::EXT_IDLE
                         && !mode_map_pkg::is_single(mode)
                         && mode != mode_map_pkg::SPECIAL_PERIPH) begin
                ext_cycle      <= 1'b1;
                ext_cycle_addr <= ext_addr;
                ext_port_c     <= (ext_word || !mode_map_pkg::is_narrow(mode))
                                  ? ext_wdata[15:8] : ext_wdata[7:0];
                ext_port_d     <= port_d_data ? ext_wdata[7:0] : 8'h00;
            end else begin
                ext_cycle      <= 1'b0;
            end
        end
    end

    assign debug_enabled = dbg[0]; // gray code bit, set unless off
    assign debug_active  = dbg[1]; // gray code bit, set when active
    assign register_block_position = act[0];
    assign ram_position    = act[1];
    assign eeprom_position = act[2];
    assign ext_busy        = ext_st[0]; // second byte pending
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_mode_frozen: assert property (
        $past(!reset) && $past(!reset, 2) |-> $stable(mode_bits))
        else $error("mode bits changed outside reset");
    a_no_reserved: assert property ($past(!reset) |-> mode_bits != 3'h6)
        else $error("reserved mode code visible");
    a_single_quiet: assert property (
        mode_map_pkg::is_single(mode) |=> !ext_cycle)
        else $error("external cycle in single-chip mode");
    a_narrow_split: assert property (
        ext_st == mode_map_pkg::EXT_IDLE && ext_start && ext_word
        && mode_map_pkg::is_narrow(mode) |=> ext_cycle ##1
        (ext_cycle && ext_cycle_addr == $past(ext_cycle_addr) + 16'h0001))
        else $error("narrow word not split into two cycles");
    a_wide_lanes: assert property (
        $past(!reset) && mode[1] |=> port_d_data && ports_ab_address)
        else $error("wide mode ports not on bus");
    a_one_select: assert property (
        access_valid |-> $onehot(access_sel))
        else $error("select not one-hot");
    a_debug_rom: assert property (
        access_valid && dbg_q && addr_q >= mode_map_pkg::DBG_ROM_FIRST
        |-> access_sel[mode_map_pkg::SEL_DBG_ROM])
        else $error("debug rom not selected");
    a_top_hidden: assert property (
        access_valid && dbg_q && addr_q >= mode_map_pkg::DBG_REG_FIRST
        |-> !access_sel[mode_map_pkg::SEL_EXT])
        else $error("user top page reachable in debug");
    a_write_locked: assert property (
        pos_wr && pos_sel == mode_map_pkg::POS_REGS && locked[0]
        && !mode_map_pkg::is_special(mode)
        |-> ##2 $stable(register_block_position))
        else $error("locked position changed");
    a_map_delay: assert property (
        $changed(register_block_position)
        |-> $past(pos_wr, 2) && $past(pos_sel, 2) == mode_map_pkg::POS_REGS)
        else $error("position changed without write two cycles back");
    a_debug_entry: assert property (
        dbg == mode_map_pkg::DBG_ENABLED && background_entry_instruction
        |=> debug_active)
        else $error("debug entry not taken");

    c_narrow_word: cover property (ext_busy ##1 ext_cycle);
    c_debug_rom: cover property (access_sel[mode_map_pkg::SEL_DBG_ROM]);
    c_remap: cover property ($changed(ram_position));
endmodule

// file: testbench/ext_memory_model.sv
// external memory model that logs the bus cycles it sees
`timescale 1ns/1ps
module ext_memory_model (
    input  wire logic        clk,   // bus clock
    input  wire logic        clear, // forget logged cycles
    input  wire logic        cyc,   // external cycle strobe
    input  wire logic [15:0] addr,  // cycle address
    input  wire logic [7:0]  hi,    // port c byte
    input  wire logic [7:0]  lo,    // port d byte
    output logic      [3:0]  cnt,   // cycles logged
    output logic      [31:0] rec0,  // first cycle seen
    output logic      [31:0] rec1   // second cycle seen
);
    // latch the first two strobed cycles as a memory device would
    always_ff @(posedge clk) begin
        if (clear) begin
            cnt <= 4'h0;
        end else if (cyc) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h0) rec0 <= {addr, hi, lo};
            if (cnt == 4'h1) rec1 <= {addr, hi, lo};
        end
    end
endmodule

// file: testbench/mode_select_resource_map_tb.sv
// self-checking bench for mode capture, port roles and mapping
`timescale 1ns/1ps
module mode_select_resource_map_tb;
    logic        clk, reset, debug_pin, mode_select_b, mode_select_a;
    logic        port_d_emulate, internal_visibility, debug_exit;
    logic        debug_enable_cmd, debug_serial_cmd, clr;
    logic        background_entry_instruction, pos_wr, bus_cycle;
    logic        extra_window_en, extra_window_direct, ext_start;
    logic        ext_word, access_valid, ext_cycle, ext_busy;
    logic        ports_ab_address, port_c_data, port_d_data;
    logic        port_e_bus_ctl, port_d_visible, cpu_inactive;
    logic        debug_enabled, debug_active, program_window_hit;
    logic        data_window_hit, extra_page_window;
    logic [1:0]  pos_sel;                  // position select
    logic [2:0]  mode_bits, m;             // seen and expected mode
    logic [7:0]  pos_data, register_block_position, ram_position;
    logic [7:0]  eeprom_position, ext_port_c, ext_port_d;
    logic [15:0] bus_addr, ext_addr, ext_wdata, ext_cycle_addr;
    logic [5:0]  access_sel;               // one-hot resource select
    logic [3:0]  cnt;                      // cycles logged by memory
    logic [31:0] rec0, rec1;               // logged cycles
    int          n_fail, checks_done;      // counters

    mode_select_resource_map uut (.clk, .reset, .debug_pin, .mode_select_b,
        .mode_select_a, .port_d_emulate, .internal_visibility, .debug_exit,
        .debug_enable_cmd, .debug_serial_cmd, .background_entry_instruction,
        .pos_wr, .pos_sel, .pos_data, .bus_cycle, .bus_addr, .extra_window_en,
        .extra_window_direct, .ext_start, .ext_word, .ext_addr, .ext_wdata,
        .mode_bits, .ports_ab_address, .port_c_data, .port_d_data,
        .port_e_bus_ctl, .port_d_visible, .cpu_inactive, .debug_enabled,
        .debug_active, .register_block_position, .ram_position,
        .eeprom_position, .access_valid, .access_sel, .program_window_hit,
        .data_window_hit, .extra_page_window, .ext_cycle, .ext_cycle_addr,
        .ext_port_c, .ext_port_d, .ext_busy);
    ext_memory_model mem (.clk(clk), .clear(clr), .cyc(ext_cycle),
        .addr(ext_cycle_addr), .hi(ext_port_c), .lo(ext_port_d),
        .cnt(cnt), .rec0(rec0), .rec1(rec1));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // reset with pin levels, then flip the pins to prove the latch
    task automatic rst(input logic [2:0] p);
        {debug_pin, mode_select_b, mode_select_a} = p;
        reset = 1'b1;
        cyc(4);
        reset = 1'b0;
        cyc(1);
        {debug_pin, mode_select_b, mode_select_a} = ~p;
        cyc(2);
    endtask
    // one access; select is registered one edge later
    task automatic dec(input logic [15:0] a, input logic [5:0] e);
        bus_addr = a;
        bus_cycle = 1'b1;
        cyc(1);
        chk(access_sel, e);
    endtask
    // position write followed by one idle cycle
    task automatic wpos(input logic [1:0] s, input logic [7:0] d);
        {pos_sel, pos_data} = {s, d};
        pos_wr = 1'b1;
        cyc(1);
        pos_wr = 1'b0;
        cyc(1);
    endtask
    // one word transfer of 1234/ABCD, logged by the memory model
    task automatic xfer();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        ext_start = 1'b1;
        cyc(1);
        ext_start = 1'b0;
        chk(ext_busy, m[1:0] == 2'h1);
        cyc(4);
    endtask
    // counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // free-running bus clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // main sequence
    initial begin
        {port_d_emulate, internal_visibility, debug_exit, clr} = 4'h0;
        {debug_enable_cmd, debug_serial_cmd, pos_wr, bus_cycle} = 4'h0;
        {background_entry_instruction, ext_start} = 2'h0;
        {extra_window_en, extra_window_direct, pos_sel, pos_data} = 'h0;
        {ext_word, ext_addr, ext_wdata, bus_addr} = {17'h11234, 32'hABCD0000};
        {n_fail, checks_done} = 64'h0;
        // every pin code: mode, port roles, debug and transfers
        for (int c = 0; c < 8; c++) begin
            rst(c[2:0]);
            m = (c == 6) ? 3'h2 : c[2:0];
            chk(mode_bits, m);
            chk(ports_ab_address, m[1:0] != 2'h0);
            chk(port_c_data, m[1:0] != 2'h0);
            chk(port_d_data, m[1]);
            chk(port_e_bus_ctl, m == 3'h3);
            chk(cpu_inactive, m == 3'h2);
            chk(debug_active, m == 3'h0);
            chk(debug_enabled, m == 3'h0);
            chk(eeprom_position, m[1:0] == 2'h0 ? 8'hF1 : 8'h11);
            xfer();
            chk(cnt, m[1:0] == 2'h0 || m == 3'h2 ? 0 : 2 - m[1]);
            if (m[1:0] == 2'h1) begin
                chk(rec0[31:8], 24'h1234AB);
                chk(rec1[31:8], 24'h1235CD);
            end
            if (m[1:0] == 2'h3) chk(rec0, 32'h1234ABCD);
        end
        // special narrow: visibility needs both bits, no write lock
        rst(3'h1);
        port_d_emulate = 1'b1;
        cyc(2);
        chk(port_d_visible, 1'b0);
        internal_visibility = 1'b1;
        cyc(2);
        chk(port_d_visible, 1'b1);
        wpos(mode_map_pkg::POS_REGS, 8'h08);
        wpos(mode_map_pkg::POS_REGS, 8'h10);
        cyc(1);
        chk(register_block_position, 8'h10);
        // normal narrow: no visibility, serial debug entry
        rst(3'h5);
        chk(port_d_visible, 1'b0);
        debug_enable_cmd = 1'b1;
        cyc(1);
        debug_enable_cmd = 1'b0;
        debug_serial_cmd = 1'b1;
        cyc(1);
        debug_serial_cmd = 1'b0;
        chk(debug_active, 1'b1);
        // normal wide: write once, settle time, precedence
        rst(3'h7);
        {pos_sel, pos_data} = {mode_map_pkg::POS_REGS, 8'h20};
        pos_wr = 1'b1;
        cyc(1);
        pos_wr = 1'b0;
        chk(register_block_position, 8'h00);
        cyc(1);
        chk(register_block_position, 8'h20);
        wpos(mode_map_pkg::POS_RAM, 8'h20);
        chk(ram_position, 8'h20);
        wpos(mode_map_pkg::POS_EE, 8'h11);
        wpos(mode_map_pkg::POS_REGS, 8'h30);
        cyc(1);
        chk(register_block_position, 8'h20);
        dec(16'h21FF, 6'h04);
        dec(16'h2200, 6'h20);
        dec(16'h2400, 6'h08);
        dec(16'h1000, 6'h10);
        dec(16'h9000, 6'h20);
        chk(program_window_hit, 1'b1);
        chk(access_valid, 1'b1);
        dec(16'h7000, 6'h20);
        chk(data_window_hit, 1'b1);
        {extra_window_en, extra_window_direct} = 2'h3;
        dec(16'h0300, 6'h20);
        chk(extra_page_window, 1'b1);
        // debug enabled only, then active by instruction, then left
        debug_enable_cmd = 1'b1;
        cyc(1);
        debug_enable_cmd = 1'b0;
        chk(debug_enabled, 1'b1);
        dec(16'hFF20, 6'h20);
        background_entry_instruction = 1'b1;
        cyc(1);
        background_entry_instruction = 1'b0;
        dec(16'hFF20, 6'h01);
        dec(16'hFF06, 6'h02);
        dec(16'hFFFE, 6'h01);
        debug_exit = 1'b1;
        cyc(1);
        debug_exit = 1'b0;
        dec(16'hFFFE, 6'h20);
        print_verdict();
    end
endmodule
